// ---- cbct_defs.vh ----
/*
  Constants of the clock buffer/counter transfer block: timing counts,
  I/O instruction codes, count modes and the register port map.
  Assumes a 125 MHz system clock; included by cbct_top.v only.
*/
`ifndef CBCT_DEFS_VH
`define CBCT_DEFS_VH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CBCT_CLK_MHZ       125
`define CBCT_TICK_NS       1000
`define CBCT_TICK_CYC      ((`CBCT_TICK_NS * `CBCT_CLK_MHZ) / 1000)
`define CBCT_PULSE_NS      300
`define CBCT_PULSE_CYC     ((`CBCT_PULSE_NS * `CBCT_CLK_MHZ + 999) / 1000)
`define CBCT_LEAD_NS       100
`define CBCT_LEAD_CYC      ((`CBCT_LEAD_NS * `CBCT_CLK_MHZ + 999) / 1000)
`define CBCT_GAP_NS        500
`define CBCT_GAP_CYC       ((`CBCT_GAP_NS * `CBCT_CLK_MHZ) / 1000)
`define CBCT_HOLD_NS       650
`define CBCT_HOLD_CYC      ((`CBCT_HOLD_NS * `CBCT_CLK_MHZ + 999) / 1000)
`define CBCT_SETTLE_NS     40
`define CBCT_SETTLE_CYC    ((`CBCT_SETTLE_NS * `CBCT_CLK_MHZ + 999) / 1000)

// ---------------------------------------------------------------
// Instruction codes (low digit of the clock's I/O group)
// ---------------------------------------------------------------
`define CBCT_OP_WRITE      3'h3
`define CBCT_OP_READ       3'h6
`define CBCT_OP_SAMPLE     3'h7

// ---------------------------------------------------------------
// Count modes
// ---------------------------------------------------------------
`define CBCT_MODE_WRAP     2'h0
`define CBCT_MODE_RELOAD   2'h1
`define CBCT_MODE_SAMPLE   2'h2
`define CBCT_MODE_SMPCLR   2'h3

// ---------------------------------------------------------------
// Register port
// ---------------------------------------------------------------
`define CBCT_REG_CTRL      2'h0
`define CBCT_REG_COUNT     2'h1
`define CBCT_REG_HOLD      2'h2
`define CBCT_CTRL_MODE_LSB 0
`define CBCT_CTRL_INHIBIT  2
`define CBCT_CTRL_RESET    3'h0

`endif

// ---- cbct_top.v ----
/*
  Buffer load and transfer logic of a programmable real-time clock:
  count pulse resynchronisation, 12-bit counter, 12-bit holding buffer,
  counter sampling safe against count edges, and the processor stall
  while the buffer is read onto the I/O bus.
  Assumes the processor bus signals are synchronous to i_clk, while the
  rate input and the three trigger inputs are asynchronous pins.
*/
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cbct_defs.vh"

module cbct_top #(
    parameter WIDTH = 12
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_init,
    input  wire             i_io_select,
    input  wire [2:0]       i_io_code,
    input  wire             i_third_timing_pulse,
    input  wire [WIDTH-1:0] i_accumulator,
    input  wire             i_rate_in,
    input  wire [2:0]       i_trigger,
    input  wire [1:0]       i_reg_addr,
    input  wire [WIDTH-1:0] i_reg_wdata,
    input  wire             i_reg_wr,
    input  wire             i_reg_rd,
    output reg  [WIDTH-1:0] o_reg_rdata,
    output reg  [WIDTH-1:0] o_bus_data,
    output reg              o_bus_data_oe,
    output reg              o_transfer_hold,
    output reg              o_transfer_strobe,
    output reg              o_count_pulse,
    output reg              o_overflow
);

    // ---------------------------------------------------------------
    // Local constants
    // ---------------------------------------------------------------
    localparam integer TICK   = `CBCT_TICK_CYC;
    localparam integer PULSE  = `CBCT_PULSE_CYC;
    localparam integer PH_A   = `CBCT_PULSE_CYC - `CBCT_LEAD_CYC;
    localparam integer PH_B   = PH_A + `CBCT_GAP_CYC;
    localparam integer HOLD   = `CBCT_HOLD_CYC;
    localparam integer SETTLE = `CBCT_SETTLE_CYC;

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_HOLD   = 3'h1;
    localparam [2:0] ST_SETTLE = 3'h2;
    localparam [2:0] ST_STROBE = 3'h3;
    localparam [2:0] ST_DONE   = 3'h4;

    localparam [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    reg             rate_s1_q;
    reg             rate_s2_q;
    reg  [2:0]      evt_s1_q;
    reg  [2:0]      evt_s2_q;
    reg             evt_s3_q;
    reg             event_q;
    reg  [6:0]      phase_q;
    reg             rate_res_q;
    reg  [6:0]      pulse_cnt_q;
    reg             go_read_q;
    reg             sampled_q;
    reg  [1:0]      mode_q;
    reg             inhibit_q;
    reg  [WIDTH-1:0] holding_q;
    reg  [WIDTH-1:0] counter_q;
    reg             preset_q;
    reg             clear_q;
    reg  [2:0]      state_q;
    reg  [6:0]      timer_q;

    wire            tick0;
    wire            sample_tick;
    wire            count_edge;
    wire            event_inhibit;
    wire            write_accumulator_to_counter;
    wire            sample_counter_cmd;
    wire            buffer_to_accumulator;
    wire            load_write;
    wire            load_sample;
    wire            load_event;
    wire            load_buffer;
    wire            accumulator_source_select;
    wire            counter_source_select;
    wire [WIDTH-1:0] buffer_src;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Each trigger pin has its own two stages; the OR comes after them
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_s1_q <= 1'b0;
            rate_s2_q <= 1'b0;
            evt_s1_q  <= 3'h0;
            evt_s2_q  <= 3'h0;
            evt_s3_q  <= 1'b0;
            event_q   <= 1'b0;
        end else begin
            rate_s1_q <= i_rate_in;
            rate_s2_q <= rate_s1_q;
            evt_s1_q  <= i_trigger;
            evt_s2_q  <= evt_s1_q;
            evt_s3_q  <= |evt_s2_q;
            event_q   <= (|evt_s2_q) & ~evt_s3_q;
        end
    end

    // ---------------------------------------------------------------
    // Divide-by-ten stage tick and count pulse
    // ---------------------------------------------------------------
    // Phase counter stands in for the first decade stage: one 1 us lap
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= 7'h00;
        end else if (phase_q == TICK[6:0] - 7'h01) begin
            phase_q <= 7'h00;
        end else begin
            phase_q <= phase_q + 7'h01;
        end
    end

    assign tick0       = (phase_q == 7'h00);
    // Two sample ticks a fixed 62 cycles (496 ns) apart, A sits 13 cycles (104 ns) before the edge
    assign sample_tick = (phase_q == PH_A[6:0]) || (phase_q == PH_B[6:0]);

    // Rate resync flop; a rising set starts a fixed-width count pulse
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_res_q  <= 1'b0;
            pulse_cnt_q <= 7'h00;
        end else begin
            if (tick0) begin
                rate_res_q <= rate_s2_q & ~inhibit_q;
            end
            if (tick0 && rate_s2_q && !inhibit_q && !rate_res_q) begin
                pulse_cnt_q <= PULSE[6:0];
            end else if (pulse_cnt_q != 7'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 7'h01;
            end
        end
    end

    // Falling end of the count pulse is the only moment the count moves
    assign count_edge = (pulse_cnt_q == 7'h01);

    // ---------------------------------------------------------------
    // Instruction decode
    // ---------------------------------------------------------------
    assign event_inhibit                = i_io_select;
    assign write_accumulator_to_counter = i_io_select && (i_io_code == `CBCT_OP_WRITE);
    assign sample_counter_cmd           = i_io_select && (i_io_code == `CBCT_OP_SAMPLE);
    assign buffer_to_accumulator        = i_io_select &&
                                          ((i_io_code == `CBCT_OP_READ) || sample_counter_cmd);

    // Registered sample-read request; held as long as the sample instruction stays selected
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            go_read_q <= 1'b0;
            sampled_q <= 1'b0;
        end else begin
            go_read_q <= sample_counter_cmd;
            if (!go_read_q) begin
                sampled_q <= 1'b0;
            end else if (sample_tick) begin
                sampled_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Load strobe and source selection
    // ---------------------------------------------------------------
    assign load_write  = write_accumulator_to_counter & i_third_timing_pulse;
    assign load_sample = go_read_q & ~sampled_q & sample_tick;
    // Events never touch the bus, only buffer, counter and the inhibit bit
    assign load_event  = event_q & mode_q[1] & ~event_inhibit;
    assign load_buffer = load_write | load_sample | load_event;

    // Exclusive selects: accumulator only for the write instruction
    assign accumulator_source_select = write_accumulator_to_counter;
    assign counter_source_select     = ~accumulator_source_select;
    assign buffer_src = accumulator_source_select ? i_accumulator : counter_q;

    // ---------------------------------------------------------------
    // Holding buffer
    // ---------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            holding_q <= {WIDTH{1'b0}};
        end else if (i_init) begin
            holding_q <= {WIDTH{1'b0}};
        end else if (load_buffer) begin
            holding_q <= buffer_src;
        end
    end

    // Follow-up actions one cycle after the buffer has taken its data
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            preset_q <= 1'b0;
            clear_q  <= 1'b0;
        end else begin
            preset_q <= load_write;
            clear_q  <= load_event && (mode_q == `CBCT_MODE_SMPCLR);
        end
    end

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    // Clear and preset beat a coinciding count edge; that count is lost
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            counter_q <= {WIDTH{1'b0}};
        end else if (clear_q) begin
            counter_q <= {WIDTH{1'b0}};
        end else if (preset_q) begin
            counter_q <= holding_q;
        end else if (count_edge) begin
            if (mode_q == `CBCT_MODE_RELOAD && counter_q == ALL_ONES) begin
                counter_q <= holding_q;
            end else begin
                counter_q <= counter_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Overflow only from a count edge at all ones (wrap or reload), never from clear or preset
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_overflow <= 1'b0;
        end else begin
            o_overflow <= count_edge && !clear_q && !preset_q &&
                          (counter_q == ALL_ONES);
        end
    end

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    // An event clearing the inhibit wins over a software write
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q    <= `CBCT_MODE_WRAP;
            inhibit_q <= 1'b0;
        end else if (i_init) begin
            mode_q    <= `CBCT_MODE_WRAP;
            inhibit_q <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == `CBCT_REG_CTRL) begin
                mode_q    <= i_reg_wdata[`CBCT_CTRL_MODE_LSB+1:`CBCT_CTRL_MODE_LSB];
                inhibit_q <= i_reg_wdata[`CBCT_CTRL_INHIBIT];
            end
            if (event_q) begin
                inhibit_q <= 1'b0;
            end
        end
    end

    // Read data valid the cycle after the strobe only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= {WIDTH{1'b0}};
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `CBCT_REG_CTRL: begin
                    o_reg_rdata <= {{(WIDTH-3){1'b0}}, inhibit_q, mode_q};
                end
                `CBCT_REG_COUNT: begin
                    o_reg_rdata <= counter_q;
                end
                `CBCT_REG_HOLD: begin
                    o_reg_rdata <= holding_q;
                end
                default: begin
                    o_reg_rdata <= {WIDTH{1'b0}};
                end
            endcase
        end else begin
            o_reg_rdata <= {WIDTH{1'b0}};
        end
    end

    // ---------------------------------------------------------------
    // Read stall sequencer
    // ---------------------------------------------------------------
    // Hold long enough that a sample tick always falls inside the stall
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q           <= ST_IDLE;
            timer_q           <= 7'h00;
            o_transfer_hold   <= 1'b0;
            o_transfer_strobe <= 1'b0;
        end else begin
            o_transfer_strobe <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (buffer_to_accumulator) begin
                        state_q         <= ST_HOLD;
                        timer_q         <= HOLD[6:0];
                        o_transfer_hold <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (timer_q == 7'h01) begin
                        state_q         <= ST_SETTLE;
                        timer_q         <= SETTLE[6:0];
                        o_transfer_hold <= 1'b0;
                    end else begin
                        timer_q <= timer_q - 7'h01;
                    end
                end
                ST_SETTLE: begin
                    if (timer_q == 7'h01) begin
                        state_q           <= ST_STROBE;
                        o_transfer_strobe <= 1'b1;
                    end else begin
                        timer_q <= timer_q - 7'h01;
                    end
                end
                ST_STROBE: begin
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    // Wait for the processor to end the instruction
                    if (!buffer_to_accumulator) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q         <= ST_IDLE;
                    o_transfer_hold <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bus data drive
    // ---------------------------------------------------------------
    // Drives zero when idle so the wired bus sees no stale data
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bus_data    <= {WIDTH{1'b0}};
            o_bus_data_oe <= 1'b0;
        end else begin
            o_bus_data    <= buffer_to_accumulator ? holding_q : {WIDTH{1'b0}};
            o_bus_data_oe <= buffer_to_accumulator;
        end
    end

    // Count pulse seen outside, mainly for observation
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count_pulse <= 1'b0;
        end else begin
            o_count_pulse <= (pulse_cnt_q != 7'h00);
        end
    end

endmodule // cbct_top

`default_nettype wire

// ---- cbct_props.sv ----
/*
  Port-level checker for cbct_top: bus stall, strobe, count pulse and
  register read timing.
  Assumes it is bound to cbct_top and that there is a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cbct_props #(
    parameter WIDTH = 12
) (
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_init,
    input wire logic             i_io_select,
    input wire logic [2:0]       i_io_code,
    input wire logic             i_third_timing_pulse,
    input wire logic [WIDTH-1:0] i_accumulator,
    input wire logic             i_rate_in,
    input wire logic [2:0]       i_trigger,
    input wire logic [1:0]       i_reg_addr,
    input wire logic [WIDTH-1:0] i_reg_wdata,
    input wire logic             i_reg_wr,
    input wire logic             i_reg_rd,
    input wire logic [WIDTH-1:0] o_reg_rdata,
    input wire logic [WIDTH-1:0] o_bus_data,
    input wire logic             o_bus_data_oe,
    input wire logic             o_transfer_hold,
    input wire logic             o_transfer_strobe,
    input wire logic             o_count_pulse,
    input wire logic             o_overflow
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [7:0] hold_cnt_q;
    logic [7:0] pulse_cnt_q;
    logic [7:0] gap_q;
    // ----------------------------------------------------------
    // Run-length counters
    // ----------------------------------------------------------
    // Counters instead of repetition: 82 cycles is too long to unroll
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_cnt_q  <= 8'h00;
            pulse_cnt_q <= 8'h00;
            gap_q       <= 8'hff;
        end else begin
            hold_cnt_q  <= o_transfer_hold ? hold_cnt_q + 8'h01 : 8'h00;
            pulse_cnt_q <= o_count_pulse ? pulse_cnt_q + 8'h01 : 8'h00;
            // Saturates so the first pulse after reset always passes
            gap_q <= (o_count_pulse && pulse_cnt_q == 8'h00) ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
        end
    end
    // Stall end followed by the strobe
    sequence s_hold_end;
        $fell(o_transfer_hold);
    endsequence
    sequence s_strobe_late;
        ##5 o_transfer_strobe;
    endsequence
    hold_len_a: assert property (s_hold_end |-> hold_cnt_q == 8'd82)
        else $error("transfer hold not 82 cycles long");
    hold_bound_a: assert property (o_transfer_hold |-> hold_cnt_q <= 8'd81)
        else $error("transfer hold overstays");
    strobe_gap_a: assert property (s_hold_end |-> s_strobe_late)
        else $error("strobe missing five cycles after hold");
    strobe_single_a: assert property (o_transfer_strobe |=> !o_transfer_strobe)
        else $error("strobe longer than one cycle");
    strobe_oe_a: assert property (o_transfer_strobe |-> o_bus_data_oe && !o_transfer_hold)
        else $error("strobe without data driven");
    hold_cause_a: assert property ($rose(o_transfer_hold) |-> $past(i_io_select)
        && ($past(i_io_code) == 3'h6 || $past(i_io_code) == 3'h7))
        else $error("stall without a read instruction");
    pulse_len_a: assert property ($fell(o_count_pulse) |-> pulse_cnt_q == 8'd38)
        else $error("count pulse not 38 cycles");
    count_gap_a: assert property ($rose(o_count_pulse) |-> gap_q >= 8'd124)
        else $error("count pulses closer than one lap");
    rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 12'h000)
        else $error("read data outside its cycle");
    unmapped_zero_a: assert property (i_reg_rd && i_reg_addr == 2'h3 |=> o_reg_rdata == 12'h000)
        else $error("unmapped read not zero");
endmodule // cbct_props

bind cbct_top cbct_props #(.WIDTH(WIDTH)) i_cbct_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_init(i_init), .i_io_select(i_io_select), .i_io_code(i_io_code),
    .i_third_timing_pulse(i_third_timing_pulse), .i_accumulator(i_accumulator), .i_rate_in(i_rate_in),
    .i_trigger(i_trigger), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
    .o_transfer_hold(o_transfer_hold), .o_transfer_strobe(o_transfer_strobe),
    .o_count_pulse(o_count_pulse), .o_overflow(o_overflow));
`default_nettype wire

// ---- cbct_cpu_model.sv ----
/*
  Behavioural processor on the I/O side of the clock block.
  Assumes the bench calls run() from a single thread, one instruction at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module cbct_cpu_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_bus_data,
    input  wire logic        i_transfer_strobe,
    output logic             o_io_select,
    output logic [2:0]       o_io_code,
    output logic             o_third_timing_pulse,
    output logic [11:0]      o_accumulator,
    output logic             o_timeout
);
    // Idle bus at time zero
    initial begin
        o_io_select          = 1'b0;
        o_io_code            = 3'h0;
        o_third_timing_pulse = 1'b0;
        o_accumulator        = 12'h000;
        o_timeout            = 1'b0;
    end
    // One instruction; slow adds cycles before the wait phase ends
    task automatic run(input logic [2:0] op, input logic [11:0] acc, input int slow, output logic [11:0] got);
        int n;
        begin
            n = 0;
            @(posedge i_clk);
            o_io_select   <= 1'b1;
            o_io_code     <= op;
            o_accumulator <= acc;
            @(posedge i_clk);
            o_third_timing_pulse <= 1'b1;
            @(posedge i_clk);
            o_third_timing_pulse <= 1'b0;
            got = acc;
            if (op != 3'h3) begin
                // Select stays up through the stall, past the gap between the two sample ticks
                #1;
                while (i_transfer_strobe !== 1'b1 && n < 200) begin
                    @(posedge i_clk);
                    #1;
                    n++;
                end
                got = i_bus_data;
                if (n == 200) o_timeout = 1'b1;
                repeat (slow) @(posedge i_clk);
            end
            // Wait phase ends; the data lines no longer hold the old value
            @(posedge i_clk);
            o_io_select   <= 1'b0;
            o_io_code     <= 3'h0;
            o_accumulator <= ~acc;
        end
    endtask
endmodule // cbct_cpu_model
`default_nettype wire

// ---- cbct_top_bench.sv ----
/*
  Self-checking bench for cbct_top: register port, instructions, counting
  and external events.
  Assumes cbct_cpu_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module cbct_top_bench;
    logic        i_clk, i_rst, i_init, i_rate_in, i_reg_wr, i_reg_rd, ovf_seen;
    logic [2:0]  i_trigger;
    logic [1:0]  i_reg_addr;
    logic [11:0] i_reg_wdata, got, v;
    wire logic [11:0] o_reg_rdata, o_bus_data, acc_bus;
    wire logic        o_bus_data_oe, o_transfer_hold, o_transfer_strobe, o_count_pulse, o_overflow;
    wire logic        sel, tp3, cpu_to;
    wire logic [2:0]  io_code;
    int          fails, checked;

    cbct_top i_cbct_top (.i_clk(i_clk), .i_rst(i_rst), .i_init(i_init), .i_io_select(sel), .i_io_code(io_code),
        .i_third_timing_pulse(tp3), .i_accumulator(acc_bus), .i_rate_in(i_rate_in), .i_trigger(i_trigger),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
        .o_transfer_hold(o_transfer_hold), .o_transfer_strobe(o_transfer_strobe),
        .o_count_pulse(o_count_pulse), .o_overflow(o_overflow));
    cbct_cpu_model i_cbct_cpu_model (.i_clk(i_clk), .i_bus_data(o_bus_data), .i_transfer_strobe(o_transfer_strobe),
        .o_io_select(sel), .o_io_code(io_code), .o_third_timing_pulse(tp3), .o_accumulator(acc_bus),
        .o_timeout(cpu_to));

    // 125 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Sticky overflow seen; the pulse is too short to poll
    always @(posedge i_clk) if (o_overflow === 1'b1) ovf_seen <= 1'b1;

    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [11:0] d);
        @(posedge i_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_chk(input string name, input logic [1:0] a, input logic [11:0] exp);
        @(posedge i_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(name, o_reg_rdata, exp);
    endtask
    // Rate high over a whole lap then low: exactly one count
    task automatic pulse_rate;
        @(posedge i_clk);
        i_rate_in <= 1'b1;
        repeat (130) @(posedge i_clk);
        i_rate_in <= 1'b0;
        repeat (170) @(posedge i_clk);
    endtask
    task automatic fire(input int b);
        @(posedge i_clk);
        i_trigger <= 3'b001 << b;
        repeat (12) @(posedge i_clk);
        i_trigger <= 3'b000;
        repeat (6) @(posedge i_clk);
    endtask
    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge i_clk);
        fails++;
        complete_run;
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {i_rst, i_init, i_rate_in, i_reg_wr, i_reg_rd, ovf_seen} = 6'b100000;
        {i_trigger, i_reg_addr, i_reg_wdata} = 17'h0_0000;
        fails = 0;
        checked = 0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        reg_chk("ctrl reset", 2'h0, 12'h000);
        reg_wr(2'h3, 12'hfff);
        reg_chk("unmapped", 2'h3, 12'h000);
        reg_chk("holding reset", 2'h2, 12'h000);
        i_cbct_cpu_model.run(3'h3, 12'h5a3, 0, got);
        reg_chk("write holding", 2'h2, 12'h5a3);
        reg_chk("write counter", 2'h1, 12'h5a3);
        pulse_rate;
        reg_chk("count", 2'h1, 12'h5a4);
        i_cbct_cpu_model.run(3'h6, 12'h000, 0, got);
        chk("read buffer", got, 12'h5a3);
        i_cbct_cpu_model.run(3'h7, 12'h000, 3, got);
        chk("sample read", got, 12'h5a4);
        reg_chk("sample holding", 2'h2, 12'h5a4);
        i_cbct_cpu_model.run(3'h3, 12'hfff, 0, got);
        ovf_seen <= 1'b0;
        pulse_rate;
        reg_chk("wrap", 2'h1, 12'h000);
        chk("overflow", {11'h000, ovf_seen}, 12'h001);
        // Every mode, each trigger input, inhibit cleared by the event
        for (int m = 0; m < 4; m++) begin
            v = 12'h8f0 + 12'(m);
            i_cbct_cpu_model.run(3'h3, v, 0, got);
            pulse_rate;
            reg_wr(2'h0, {9'h000, 1'b1, 2'(m)});
            ovf_seen <= 1'b0;
            fire(m % 3);
            reg_chk("event holding", 2'h2, (m >= 2) ? v + 12'h001 : v);
            reg_chk("event counter", 2'h1, (m == 3) ? 12'h000 : v + 12'h001);
            reg_chk("event ctrl", 2'h0, {10'h000, 2'(m)});
            chk("clear overflow", {11'h000, ovf_seen}, 12'h000);
        end
        // Event during a buffer read must not become a sample
        reg_wr(2'h0, 12'h002);
        i_cbct_cpu_model.run(3'h3, 12'h123, 0, got);
        pulse_rate;
        fork
            i_cbct_cpu_model.run(3'h6, 12'h000, 0, got);
            begin
                repeat (20) @(posedge i_clk);
                i_trigger <= 3'b010;
            end
        join
        i_trigger <= 3'b000;
        repeat (6) @(posedge i_clk);
        chk("inhibited read", got, 12'h123);
        reg_chk("inhibited holding", 2'h2, 12'h123);
        @(posedge i_clk);
        i_init <= 1'b1;
        @(posedge i_clk);
        i_init <= 1'b0;
        reg_chk("init holding", 2'h2, 12'h000);
        chk("bus wait", {11'h000, cpu_to}, 12'h000);
        complete_run;
    end
endmodule // cbct_top_bench
`default_nettype wire
